// file: hdl/ring_engine_pkg.sv
// shared constants, register map and state encoding for the packed ring queue engine
package ring_engine_pkg;

  // ==========================================================================
  // register map (byte addresses on the register port)
  // ==========================================================================
  localparam logic [7:0]  REG_CTRL      = 8'h00;  // enable, event index, error clear
  localparam logic [7:0]  REG_RING_LO   = 8'h04;  // descriptor ring base, low word
  localparam logic [7:0]  REG_RING_HI   = 8'h08;  // descriptor ring base, high word
  localparam logic [7:0]  REG_QSIZE     = 8'h0C;  // queue size in descriptors
  localparam logic [7:0]  REG_EVT_LO    = 8'h10;  // driver suppression structure, low word
  localparam logic [7:0]  REG_EVT_HI    = 8'h14;  // driver suppression structure, high word
  localparam logic [7:0]  REG_MAX_CHAIN = 8'h18;  // list length limit, zero means queue size
  localparam logic [7:0]  REG_STATUS    = 8'h1C;  // available position, wrap counters, error, busy
  localparam logic [7:0]  REG_USED_POS  = 8'h20;  // used ring position

  localparam int CTRL_EN_BIT      = 0;
  localparam int CTRL_EVIDX_BIT   = 1;
  localparam int CTRL_ERR_CLR_BIT = 2;
  localparam logic [1:0]  CTRL_RST      = 2'h0;
  localparam logic [15:0] QSIZE_RST     = 16'h0100;
  localparam logic [15:0] MAX_CHAIN_RST = 16'h0000;

  localparam int STAT_AWRAP_BIT = 16;
  localparam int STAT_UWRAP_BIT = 17;
  localparam int STAT_ERR_BIT   = 18;
  localparam int STAT_BUSY_BIT  = 19;

  // ==========================================================================
  // descriptor layout: four little-endian words of one ring entry
  // ==========================================================================
  localparam int          DESC_SHIFT  = 4;      // 16 bytes per entry
  localparam logic [1:0]  W_ADDR_LO   = 2'h0;
  localparam logic [1:0]  W_ADDR_HI   = 2'h1;
  localparam logic [1:0]  W_LEN       = 2'h2;
  localparam logic [1:0]  W_ID_FLAGS  = 2'h3;   // id in bits 15:0, flags in 31:16
  localparam int          WORD_SHIFT  = 2;
  localparam int          FLAG_NEXT   = 0;
  localparam int          FLAG_WRITE  = 1;
  localparam int          FLAG_AVAIL  = 7;
  localparam int          FLAG_USED   = 15;

  // ==========================================================================
  // event suppression structure: one 32-bit word
  // ==========================================================================
  localparam int          EVT_OFF_LSB   = 0;
  localparam int          EVT_OFF_MSB   = 14;
  localparam int          EVT_WRAP_BIT  = 15;
  localparam int          EVT_FLAGS_LSB = 16;
  localparam int          EVT_FLAGS_MSB = 17;
  localparam logic [1:0]  EVT_ENABLE    = 2'h0;
  localparam logic [1:0]  EVT_DISABLE   = 2'h1;
  localparam logic [1:0]  EVT_DESC      = 2'h2;

  localparam logic [15:0] POS_RST  = 16'h0000;
  localparam logic        WRAP_RST = 1'b1;

  // engine states, gray coded along the usual path
  typedef enum logic [2:0] {
    S_IDLE     = 3'b000,
    S_RD_FLAGS = 3'b001,
    S_RD_BODY  = 3'b011,
    S_EMIT     = 3'b010,
    S_WAIT     = 3'b110,
    S_WR_LEN   = 3'b111,
    S_WR_FLAGS = 3'b101,
    S_RD_EVT   = 3'b100
  } eng_state_t;

endpackage

// file: hdl/ring_pointer.sv
// ring position with wrap counter, stepping modulo an arbitrary queue size
`timescale 1ns/1ps
module ring_pointer
  import ring_engine_pkg::*;
(
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        sys_rst_in,
  input  wire logic        ce_in,
  // control
  input  wire logic        clear_in,
  input  wire logic        adv_in,
  input  wire logic [15:0] step_in,
  input  wire logic [15:0] size_in,
  // state
  output logic      [15:0] pos_out,
  output logic             wrap_out
);

  logic [15:0] pos_q, pos_d;
  logic        wrap_q, wrap_d;
  logic [16:0] sum;

  // ==========================================================================
  // next position: subtract the size instead of masking, any size works
  // ==========================================================================
  always_comb begin
    sum    = {1'b0, pos_q} + {1'b0, step_in};
    pos_d  = pos_q;
    wrap_d = wrap_q;
    if (clear_in) begin
      pos_d  = POS_RST;
      wrap_d = WRAP_RST;
    end else if (adv_in) begin
      if (sum >= {1'b0, size_in}) begin
        pos_d  = 16'(sum - {1'b0, size_in});
        wrap_d = ~wrap_q;
      end else begin
        pos_d = sum[15:0];
      end
    end
  end

  // registers
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      pos_q  <= POS_RST;
      wrap_q <= WRAP_RST;
    end else if (ce_in) begin
      pos_q  <= pos_d;
      wrap_q <= wrap_d;
    end
  end

  assign pos_out  = pos_q;
  assign wrap_out = wrap_q;

endmodule

// file: hdl/event_check.sv
// decides from the driver suppression word whether a used-buffer notification fires
`timescale 1ns/1ps
module event_check
  import ring_engine_pkg::*;
(
  // inputs
  input  wire logic [31:0] evt_word_in,
  input  wire logic        event_idx_in,
  input  wire logic [15:0] used_pos_in,
  input  wire logic        used_wrap_in,
  // result
  output logic             fire_out
);

  logic [1:0]  mode;
  logic [14:0] off;
  logic        wrap;

  // ==========================================================================
  // field decode and mode select
  // ==========================================================================
  always_comb begin
    mode = evt_word_in[EVT_FLAGS_MSB:EVT_FLAGS_LSB];
    off  = evt_word_in[EVT_OFF_MSB:EVT_OFF_LSB];
    wrap = evt_word_in[EVT_WRAP_BIT];
    unique case (mode)
      EVT_ENABLE:  fire_out = 1'b1;
      EVT_DISABLE: fire_out = 1'b0;
      // without event index the descriptor mode is invalid: treat as enabled
      EVT_DESC:    fire_out = event_idx_in ?
                              ((used_pos_in == {1'b0, off}) && (used_wrap_in == wrap)) :
                              1'b1;
      default:     fire_out = 1'b0;                   // reserved code
    endcase
  end

endmodule

// file: hdl/packed_ring_queue_engine.sv
// device-side packed descriptor ring engine: fetch, hand out, complete, notify
`timescale 1ns/1ps
// Overview of operation
// - write the list's single used entry, flags word last, after its length word.
// - suppression mode 0 enables, 1 disables, 2 selects one descriptor, 3 reserved.
// - descriptor mode only honoured with event index on; otherwise treated as enable.
// - descriptor mode fires only when the programmed offset entry is used.
// - descriptor mode also needs the used wrap counter to match the wrap bit.
// - after writing used entries read the driver suppression word before notifying.
// - the device only reads the driver suppression structure, never writes it.
// - ring positions step modulo any queue size, power of two or not.
// - available entries fetched in ring order, used entries written in completion order.
// - entry is address 64, length 32, id 16, flags 16, little endian.
// - consume an entry only once its available flag has changed from before.
// - suppression word holds 15-bit offset, wrap bit, and two mode bits.
// - never report writes into read-only buffers; write flag only for writable lists.
// - no change to an entry after its used flag was written.
// - list entries used in posted order; device caps list length.
// - used entry gets used and available flags equal to the used wrap counter.
// - flag bit 0 marks an entry that continues into the next one.
module packed_ring_queue_engine
  import ring_engine_pkg::*;
(
  // clock, reset, enable
  input  wire logic        clock_in,
  input  wire logic        sys_rst_in,
  input  wire logic        ce_in,
  // register port
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [31:0] reg_rdata_out,
  // shared memory master
  output logic             mem_req_out,
  output logic             mem_we_out,
  output logic      [63:0] mem_addr_out,
  output logic      [31:0] mem_wdata_out,
  input  wire logic        mem_ack_in,
  input  wire logic [31:0] mem_rdata_in,
  // descriptor stream to the user
  output logic             desc_valid_out,
  output logic      [63:0] desc_addr_out,
  output logic      [31:0] desc_len_out,
  output logic             desc_write_out,
  output logic             desc_last_out,
  input  wire logic        desc_ready_in,
  // completion from the user
  input  wire logic        comp_valid_in,
  input  wire logic [31:0] comp_len_in,
  output logic             comp_ready_out,
  // used-buffer notification
  output logic             notify_out
);

  // ==========================================================================
  // register file
  // ==========================================================================
  logic [1:0]  ctrl_q, ctrl_d;
  logic [31:0] ring_lo_q, ring_lo_d, ring_hi_q, ring_hi_d;
  logic [31:0] evt_lo_q, evt_lo_d, evt_hi_q, evt_hi_d;
  logic [15:0] qsize_q, qsize_d, max_chain_q, max_chain_d;
  logic [31:0] rdata_q, rdata_d;
  logic        err_clr;

  // ring pointers and event decision
  logic [15:0] avail_pos, used_pos;
  logic        avail_wrap, used_wrap;
  logic        avail_adv, used_adv;
  logic [15:0] used_step;
  logic        evt_fire;

  // engine state
  eng_state_t  state_q, state_d;
  logic [1:0]  word_q, word_d;
  logic [15:0] chain_q, chain_d;
  logic [15:0] flags_q, flags_d, id_q, id_d;
  logic        any_wr_q, any_wr_d, err_q, err_d;
  logic [31:0] clen_q, clen_d;
  logic [15:0] ev_pos_q, ev_pos_d;
  logic        ev_wrap_q, ev_wrap_d;
  logic        mreq_q, mreq_d, mwe_q, mwe_d;
  logic [63:0] maddr_q, maddr_d;
  logic [31:0] mwdata_q, mwdata_d;
  logic        dvalid_q, dvalid_d, dwrite_q, dwrite_d, dlast_q, dlast_d;
  logic [63:0] daddr_q, daddr_d;
  logic [31:0] dlen_q, dlen_d;
  logic        cready_q, cready_d, notify_q, notify_d;

  // helpers
  logic [63:0] ring_base, evt_addr;
  logic [63:0] avail_entry, used_entry;
  logic [15:0] limit, chain_inc;
  logic [15:0] rd_flags;
  logic        enabled, is_avail, at_limit;

  // register decode, reads answer in the next cycle only
  always_comb begin
    ctrl_d      = ctrl_q;
    ring_lo_d   = ring_lo_q;
    ring_hi_d   = ring_hi_q;
    evt_lo_d    = evt_lo_q;
    evt_hi_d    = evt_hi_q;
    qsize_d     = qsize_q;
    max_chain_d = max_chain_q;
    rdata_d     = 32'h0000_0000;
    err_clr     = reg_wr_in && (reg_addr_in == REG_CTRL) && reg_wdata_in[CTRL_ERR_CLR_BIT];
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        REG_CTRL:      ctrl_d      = reg_wdata_in[1:0];
        REG_RING_LO:   ring_lo_d   = reg_wdata_in;
        REG_RING_HI:   ring_hi_d   = reg_wdata_in;
        REG_QSIZE:     qsize_d     = reg_wdata_in[15:0];
        REG_EVT_LO:    evt_lo_d    = reg_wdata_in;
        REG_EVT_HI:    evt_hi_d    = reg_wdata_in;
        REG_MAX_CHAIN: max_chain_d = reg_wdata_in[15:0];
        default:       ;
      endcase
    end
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        REG_CTRL:      rdata_d = {30'h0000_0000, ctrl_q};
        REG_RING_LO:   rdata_d = ring_lo_q;
        REG_RING_HI:   rdata_d = ring_hi_q;
        REG_QSIZE:     rdata_d = {16'h0000, qsize_q};
        REG_EVT_LO:    rdata_d = evt_lo_q;
        REG_EVT_HI:    rdata_d = evt_hi_q;
        REG_MAX_CHAIN: rdata_d = {16'h0000, max_chain_q};
        REG_STATUS:    rdata_d = {12'h000, (state_q != S_IDLE), err_q, used_wrap, avail_wrap, avail_pos};
        REG_USED_POS:  rdata_d = {16'h0000, used_pos};
        default:       rdata_d = 32'h0000_0000;  // unmapped reads as zero
      endcase
    end
  end

  // register file flops
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      ctrl_q      <= CTRL_RST;
      ring_lo_q   <= 32'h0000_0000;
      ring_hi_q   <= 32'h0000_0000;
      evt_lo_q    <= 32'h0000_0000;
      evt_hi_q    <= 32'h0000_0000;
      qsize_q     <= QSIZE_RST;
      max_chain_q <= MAX_CHAIN_RST;
      rdata_q     <= 32'h0000_0000;
    end else if (ce_in) begin
      ctrl_q      <= ctrl_d;
      ring_lo_q   <= ring_lo_d;
      ring_hi_q   <= ring_hi_d;
      evt_lo_q    <= evt_lo_d;
      evt_hi_q    <= evt_hi_d;
      qsize_q     <= qsize_d;
      max_chain_q <= max_chain_d;
      rdata_q     <= rdata_d;
    end
  end

  // ==========================================================================
  // ring pointers and suppression decision
  // ==========================================================================
  ring_pointer u_avail_ptr (
    .clock_in   (clock_in),
    .sys_rst_in (sys_rst_in),
    .ce_in      (ce_in),
    .clear_in   (~enabled),
    .adv_in     (avail_adv),
    .step_in    (16'h0001),
    .size_in    (qsize_q),
    .pos_out    (avail_pos),
    .wrap_out   (avail_wrap)
  );

  ring_pointer u_used_ptr (
    .clock_in   (clock_in),
    .sys_rst_in (sys_rst_in),
    .ce_in      (ce_in),
    .clear_in   (~enabled),
    .adv_in     (used_adv),
    .step_in    (used_step),
    .size_in    (qsize_q),
    .pos_out    (used_pos),
    .wrap_out   (used_wrap)
  );

  event_check u_event_check (
    .evt_word_in  (mem_rdata_in),
    .event_idx_in (ctrl_q[CTRL_EVIDX_BIT]),
    .used_pos_in  (ev_pos_q),
    .used_wrap_in (ev_wrap_q),
    .fire_out     (evt_fire)
  );

  // addresses assume the driver's 16-byte ring and 4-byte structure alignment
  assign enabled     = ctrl_q[CTRL_EN_BIT];
  assign ring_base   = {ring_hi_q, ring_lo_q};
  assign evt_addr    = {evt_hi_q, evt_lo_q};
  assign avail_entry = ring_base + {44'h0000_0000_000, avail_pos, 4'h0};
  assign used_entry  = ring_base + {44'h0000_0000_000, used_pos, 4'h0};
  assign limit       = (max_chain_q == 16'h0000 || max_chain_q > qsize_q) ? qsize_q : max_chain_q;
  assign chain_inc   = chain_q + 16'h0001;
  assign rd_flags    = mem_rdata_in[31:16];

  // ==========================================================================
  // engine: fetch available entries, hand out, complete, write used, notify
  // ==========================================================================
  always_comb begin
    state_d   = state_q;
    word_d    = word_q;
    chain_d   = chain_q;
    flags_d   = flags_q;
    id_d      = id_q;
    any_wr_d  = any_wr_q;
    err_d     = err_q;
    clen_d    = clen_q;
    ev_pos_d  = ev_pos_q;
    ev_wrap_d = ev_wrap_q;
    mreq_d    = mreq_q;
    mwe_d     = mwe_q;
    maddr_d   = maddr_q;
    mwdata_d  = mwdata_q;
    dvalid_d  = dvalid_q;
    daddr_d   = daddr_q;
    dlen_d    = dlen_q;
    dwrite_d  = dwrite_q;
    dlast_d   = dlast_q;
    cready_d  = cready_q;
    notify_d  = 1'b0;
    avail_adv = 1'b0;
    used_adv  = 1'b0;
    used_step = chain_q;
    at_limit  = (chain_inc >= limit);
    // available when avail flag equals the wrap counter and used flag differs
    is_avail  = (rd_flags[FLAG_AVAIL] == avail_wrap) && (rd_flags[FLAG_USED] != avail_wrap);
    if (err_clr) begin
      err_d = 1'b0;
    end
    unique case (state_q)
      S_IDLE: begin
        chain_d  = 16'h0000;
        any_wr_d = 1'b0;
        if (enabled) begin
          state_d = S_RD_FLAGS;
        end
      end
      // poll only the next entry in ring order
      S_RD_FLAGS: begin
        if (!mreq_q) begin
          mreq_d  = 1'b1;
          mwe_d   = 1'b0;
          maddr_d = avail_entry + {60'h0, W_ID_FLAGS, 2'h0};
        end else if (mem_ack_in) begin
          mreq_d = 1'b0;
          if (is_avail) begin
            flags_d = rd_flags;
            id_d    = mem_rdata_in[15:0];
            word_d  = W_ADDR_LO;
            state_d = S_RD_BODY;
          end else if (chain_q == 16'h0000) begin
            state_d = S_IDLE;
          end
        end
      end
      S_RD_BODY: begin
        if (!mreq_q) begin
          mreq_d  = 1'b1;
          mwe_d   = 1'b0;
          maddr_d = avail_entry + {60'h0, word_q, 2'h0};
        end else if (mem_ack_in) begin
          mreq_d = 1'b0;
          word_d = 2'(word_q + 2'h1);
          unique case (word_q)
            W_ADDR_LO: daddr_d[31:0]  = mem_rdata_in;
            W_ADDR_HI: daddr_d[63:32] = mem_rdata_in;
            default: begin
              dlen_d   = mem_rdata_in;
              dwrite_d = flags_q[FLAG_WRITE];
              // a continuing entry that reaches the limit is cut off as the last
              dlast_d  = !flags_q[FLAG_NEXT] || at_limit;
              dvalid_d = 1'b1;
              state_d  = S_EMIT;
            end
          endcase
        end
      end
      // hand entries out in the order posted
      S_EMIT: begin
        if (desc_ready_in) begin
          dvalid_d  = 1'b0;
          avail_adv = 1'b1;
          chain_d   = chain_inc;
          any_wr_d  = any_wr_q | flags_q[FLAG_WRITE];
          if (flags_q[FLAG_NEXT] && at_limit) begin
            err_d = 1'b1;
          end
          if (!dlast_q) begin
            state_d = S_RD_FLAGS;
          end else begin
            cready_d = 1'b1;
            state_d  = S_WAIT;
          end
        end
      end
      S_WAIT: begin
        if (comp_valid_in) begin
          cready_d = 1'b0;
          clen_d   = any_wr_q ? comp_len_in : 32'h0000_0000;
          state_d  = S_WR_LEN;
        end
      end
      // length word first, flags word last so the entry appears complete
      S_WR_LEN: begin
        if (!mreq_q) begin
          mreq_d   = 1'b1;
          mwe_d    = 1'b1;
          maddr_d  = used_entry + {60'h0, W_LEN, 2'h0};
          mwdata_d = clen_q;
        end else if (mem_ack_in) begin
          mreq_d  = 1'b0;
          state_d = S_WR_FLAGS;
        end
      end
      S_WR_FLAGS: begin
        if (!mreq_q) begin
          mreq_d   = 1'b1;
          mwe_d    = 1'b1;
          maddr_d  = used_entry + {60'h0, W_ID_FLAGS, 2'h0};
          mwdata_d = {used_wrap, 7'h00, used_wrap, 5'h00, any_wr_q, 1'b0, id_q};
        end else if (mem_ack_in) begin
          mreq_d    = 1'b0;
          ev_pos_d  = used_pos;
          ev_wrap_d = used_wrap;
          used_adv  = 1'b1;                          // skip the whole list
          state_d   = S_RD_EVT;                      // entry never touched again
        end
      end
      // read-only access to the driver suppression word
      S_RD_EVT: begin
        if (!mreq_q) begin
          mreq_d  = 1'b1;
          mwe_d   = 1'b0;
          maddr_d = evt_addr;
        end else if (mem_ack_in) begin
          mreq_d   = 1'b0;
          notify_d = evt_fire;
          state_d  = S_IDLE;
        end
      end
    endcase
  end

  // engine flops
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      state_q   <= S_IDLE;
      word_q    <= W_ADDR_LO;
      chain_q   <= 16'h0000;
      flags_q   <= 16'h0000;
      id_q      <= 16'h0000;
      any_wr_q  <= 1'b0;
      err_q     <= 1'b0;
      clen_q    <= 32'h0000_0000;
      ev_pos_q  <= POS_RST;
      ev_wrap_q <= WRAP_RST;
      mreq_q    <= 1'b0;
      mwe_q     <= 1'b0;
      maddr_q   <= 64'h0000_0000_0000_0000;
      mwdata_q  <= 32'h0000_0000;
      dvalid_q  <= 1'b0;
      daddr_q   <= 64'h0000_0000_0000_0000;
      dlen_q    <= 32'h0000_0000;
      dwrite_q  <= 1'b0;
      dlast_q   <= 1'b0;
      cready_q  <= 1'b0;
      notify_q  <= 1'b0;
    end else if (ce_in) begin
      state_q   <= state_d;
      word_q    <= word_d;
      chain_q   <= chain_d;
      flags_q   <= flags_d;
      id_q      <= id_d;
      any_wr_q  <= any_wr_d;
      err_q     <= err_d;
      clen_q    <= clen_d;
      ev_pos_q  <= ev_pos_d;
      ev_wrap_q <= ev_wrap_d;
      mreq_q    <= mreq_d;
      mwe_q     <= mwe_d;
      maddr_q   <= maddr_d;
      mwdata_q  <= mwdata_d;
      dvalid_q  <= dvalid_d;
      daddr_q   <= daddr_d;
      dlen_q    <= dlen_d;
      dwrite_q  <= dwrite_d;
      dlast_q   <= dlast_d;
      cready_q  <= cready_d;
      notify_q  <= notify_d;
    end
  end

  // outputs straight from flops
  assign reg_rdata_out  = rdata_q;
  assign mem_req_out    = mreq_q;
  assign mem_we_out     = mwe_q;
  assign mem_addr_out   = maddr_q;
  assign mem_wdata_out  = mwdata_q;
  assign desc_valid_out = dvalid_q;
  assign desc_addr_out  = daddr_q;
  assign desc_len_out   = dlen_q;
  assign desc_write_out = dwrite_q;
  assign desc_last_out  = dlast_q;
  assign comp_ready_out = cready_q;
  assign notify_out     = notify_q;

endmodule

// file: sim/packed_ring_queue_engine_props.sv
// port checks for the packed ring queue engine
`timescale 1ns/1ps
module packed_ring_queue_engine_props (
  // watched ports
  input wire logic        clock_in,
  input wire logic        sys_rst_in,
  input wire logic        reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic        mem_req_out,
  input wire logic        mem_we_out,
  input wire logic [63:0] mem_addr_out,
  input wire logic [31:0] mem_wdata_out,
  input wire logic        mem_ack_in,
  input wire logic        desc_valid_out,
  input wire logic        desc_ready_in,
  input wire logic [63:0] desc_addr_out,
  input wire logic        comp_valid_in,
  input wire logic        comp_ready_out,
  input wire logic        notify_out
);
  // ==========================================================================
  // properties
  // ==========================================================================
  default clocking @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_len_done;
    mem_req_out && mem_ack_in && mem_we_out && mem_addr_out[3:0] == 4'h8;
  endsequence
  sequence s_flag_wr;
    mem_req_out && mem_we_out && mem_addr_out[3:0] == 4'hC;
  endsequence
  a_used_last: assert property (s_len_done |-> ##[1:9] s_flag_wr)
    else $error("flags word not written after length");
  a_used_match: assert property (s_flag_wr |-> mem_wdata_out[31] == mem_wdata_out[23])
    else $error("used and avail flags differ");
  a_write_place: assert property (mem_req_out && mem_we_out |-> mem_addr_out[3])
    else $error("write outside length or flags word");
  a_req_hold: assert property (mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out))
    else $error("memory request changed before ack");
  a_notify_src: assert property (notify_out |-> $past(mem_ack_in) && !$past(mem_we_out) && !mem_req_out)
    else $error("notify without suppression read");
  a_notify_pulse: assert property (notify_out |=> !notify_out)
    else $error("notify longer than one cycle");
  a_desc_hold: assert property (desc_valid_out && !desc_ready_in |=> desc_valid_out && $stable(desc_addr_out))
    else $error("descriptor dropped before ready");
  a_comp_drop: assert property (comp_ready_out && comp_valid_in |=> !comp_ready_out)
    else $error("completion ready held after take");
  a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
    else $error("read data outside answer cycle");
endmodule
bind packed_ring_queue_engine packed_ring_queue_engine_props i_props (.*);

// file: sim/ring_mem_model.sv
// shared memory holding the ring, standing for the driver side
`timescale 1ns/1ps
module ring_mem_model (
  // memory port
  input  wire logic        clock_in,
  input  wire logic        req_in,
  input  wire logic        we_in,
  input  wire logic [63:0] addr_in,
  input  wire logic [31:0] wdata_in,
  output logic             ack_out = 1'b0,
  output logic      [31:0] rdata_out = 32'h0
);
  // ==========================================================================
  // storage and answers
  // ==========================================================================
  logic [31:0] mem [0:255];
  logic [1:0]  cnt = 2'h0;
  logic        slow = 1'b0;
  // ring starts zeroed
  initial for (int i = 0; i < 256; i++) mem[i] = 32'h0;
  // answers alternate prompt and slow; data toggle outside the ack cycle
  always @(posedge clock_in) begin
    ack_out <= 1'b0;
    rdata_out <= ~rdata_out;
    if (req_in && !ack_out) begin
      cnt <= cnt + 2'h1;
      if (cnt == {slow, 1'b0}) begin
        ack_out <= 1'b1;
        cnt <= 2'h0;
        slow <= ~slow;
        rdata_out <= mem[addr_in[9:2]];
        if (we_in) mem[addr_in[9:2]] <= wdata_in;
      end
    end
  end
endmodule

// file: sim/tb.sv
// self-checking bench for the packed ring queue engine
`timescale 1ns/1ps
module tb;
  import ring_engine_pkg::*;
  // ==========================================================================
  // signals, clock, instances
  // ==========================================================================
  logic        clock_in = 1'b0, sys_rst_in = 1'b1;
  logic        reg_wr_in = 1'b0, reg_rd_in = 1'b0, ce_in = 1'b1;
  logic        desc_ready_in = 1'b0, comp_valid_in = 1'b0;
  logic [7:0]  reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0, comp_len_in = 32'h0, reg_rdata_out, mem_wdata_out, mem_rdata_in, desc_len_out;
  logic [63:0] mem_addr_out, desc_addr_out;
  logic        mem_req_out, mem_we_out, mem_ack_in, desc_valid_out, desc_write_out, desc_last_out, comp_ready_out;
  logic        notify_out;
  int          mismatches = 0, compares = 0, cyc = 0, nf = 0;
  // clock of 4 ns
  always #2 clock_in = ~clock_in;
  packed_ring_queue_engine i_dut (.*);
  ring_mem_model i_mem (.clock_in(clock_in), .req_in(mem_req_out), .we_in(mem_we_out), .addr_in(mem_addr_out),
    .wdata_in(mem_wdata_out), .ack_out(mem_ack_in), .rdata_out(mem_rdata_in));
  // notify count and hang limit
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    nf <= nf + int'(notify_out === 1'b1);
    if (cyc == 20000) begin
      mismatches++;
      finish_test();
    end
  end
  // ==========================================================================
  // tasks
  // ==========================================================================
  task chk(string n, logic [31:0] e, logic [31:0] s);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(logic [7:0] a, logic [31:0] d);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clock_in);
    reg_wr_in <= 1'b0;
    @(posedge clock_in);
  endtask
  task rc(logic [7:0] a, logic [31:0] m, logic [31:0] e);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clock_in);
    reg_rd_in <= 1'b0;
    #1 chk("reg", e, reg_rdata_out & m);
    @(posedge clock_in);
  endtask
  // one ring entry: address, length, id, flags
  task put(int p, logic [31:0] len, logic [15:0] fl);
    i_mem.mem[p*4] <= 32'h1000 * (p + 1);
    i_mem.mem[p*4+1] <= 32'h0;
    i_mem.mem[p*4+2] <= len;
    i_mem.mem[p*4+3] <= {fl, 16'(p + 5)};
    @(posedge clock_in);
  endtask
  // take n descriptors, complete, check used entry and notify count
  task serve(int p, int n, logic [31:0] w3, logic [31:0] lx, int dn);
    int i, t, n0;
    n0 = nf;
    for (i = 0; i < n; i++) begin
      t = 0;
      while (desc_valid_out !== 1'b1 && t < 300) begin @(posedge clock_in); t++; end
      chk("desc_addr", 32'h1000 * (p + i + 1), desc_addr_out[31:0]);
      chk("desc_last", 32'(i == n - 1), 32'(desc_last_out));
      chk("desc_len_wr", {i_mem.mem[(p+i)*4+2][30:0], i_mem.mem[(p+i)*4+3][17]}, {desc_len_out[30:0], desc_write_out});
      desc_ready_in <= 1'b1;
      @(posedge clock_in);
      desc_ready_in <= 1'b0;
      @(posedge clock_in);
    end
    t = 0;
    while (comp_ready_out !== 1'b1 && t < 300) begin @(posedge clock_in); t++; end
    comp_valid_in <= 1'b1;
    comp_len_in <= 32'h40;
    @(posedge clock_in);
    comp_valid_in <= 1'b0;
    repeat (80) @(posedge clock_in);
    chk("used_len", lx, i_mem.mem[p*4+2]);
    chk("used_flags", w3, i_mem.mem[p*4+3]);
    chk("notify", dn, nf - n0);
  endtask
  task finish_test();
    if (mismatches == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ==========================================================================
  // sequence
  // ==========================================================================
  initial begin
    repeat (20) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    ce_in <= 1'b0;
    wr(REG_QSIZE, 32'h5);
    ce_in <= 1'b1;
    rc(REG_QSIZE, 32'hFFFF, 32'h0100);
    rc(REG_STATUS, 32'h3FFFF, 32'h30000);
    rc(8'hFC, 32'hFFFFFFFF, 32'h0);
    wr(REG_QSIZE, 32'h3);
    wr(REG_EVT_LO, 32'h3F0);
    wr(REG_CTRL, 32'h3);
    repeat (60) @(posedge clock_in);
    chk("idle", 32'h0, 32'(desc_valid_out));
    put(1, 32'h20, 16'h0082);
    put(0, 32'h10, 16'h0081);
    serve(0, 2, 32'h80820006, 32'h40, 1);
    rc(REG_USED_POS, 32'hFFFF, 32'h2);
    i_mem.mem[252] <= 32'h00010000;
    put(2, 32'h30, 16'h0080);
    serve(2, 1, 32'h80800007, 32'h0, 0);
    rc(REG_STATUS, 32'h3FFFF, 32'h0);
    i_mem.mem[252] <= 32'h00020000;
    put(0, 32'h10, 16'h8002);
    serve(0, 1, 32'h00020005, 32'h40, 1);
    i_mem.mem[252] <= 32'h00020002;
    put(1, 32'h10, 16'h8002);
    serve(1, 1, 32'h00020006, 32'h40, 0);
    finish_test();
  end
endmodule
